// *** hdl/srqe_cfg.svh ***
`ifndef SRQE_CFG_SVH
`define SRQE_CFG_SVH
`define SRQE_RESP_OK           8'h00
`define SRQE_RESP_OVERRUN      8'h01
`define SRQE_RESP_ABORT        8'h02
`define SRQE_RESP_BAD_TARGET   8'h03
`define SRQE_RESP_RESET        8'h04
`define SRQE_RESP_BUSY         8'h05
`define SRQE_RESP_TRANSPORT    8'h06
`define SRQE_RESP_TGT_FAILURE  8'h07
`define SRQE_RESP_NEXUS        8'h08
`define SRQE_RESP_FAILURE      8'h09
`define SRQE_ATTR_SIMPLE       8'h00
`define SRQE_ATTR_ORDERED      8'h01
`define SRQE_ATTR_HEAD         8'h02
`define SRQE_ATTR_ACA          8'h03
`define SRQE_SENSE_SIZE_RST    32'h0000_0060
`define SRQE_CDB_SIZE_RST      32'h0000_0020
`define SRQE_ADDR_FORM_TARGET  8'h01
`define SRQE_RLUN_BYTE0        8'hc1
`define SRQE_RLUN_BYTE1        8'h01
`define SRQE_HDR_FIXED_BYTES   32'h0000_0013
`define SRQE_HDR_PI_BYTES      32'h0000_0008
`define SRQE_FEAT_INOUT_BIT    0
`endif

// *** hdl/srqe_pkg.sv ***
package srqe_pkg;
  typedef enum logic [2:0] {
    SRQE_FAULT_NONE,
    SRQE_FAULT_TRANSPORT,
    SRQE_FAULT_TARGET,
    SRQE_FAULT_NEXUS,
    SRQE_FAULT_BUSY,
    SRQE_FAULT_OTHER
  } srqe_fault_e;

  typedef struct packed {
    logic [7:0]  queue_id;
    logic [63:0] lun;
    logic [63:0] command_tag;
    logic [7:0]  task_attr;
    logic [7:0]  prio;
    logic [7:0]  crn;
    logic        implicit_head;
    logic [31:0] demand_length;
    logic [31:0] protect_out_length;
    logic [31:0] protect_in_length;
    logic [31:0] dataout_length;
    logic [31:0] datain_length;
  } srqe_req_s;

  typedef struct packed {
    logic        report_luns;
    logic [7:0]  target;
    logic [13:0] unit;
    logic [63:0] command_tag;
    logic [7:0]  task_attr;
    logic [31:0] cdb_bytes;
    logic [31:0] dataout_offset;
    logic [31:0] dataout_length;
    logic [31:0] datain_length;
  } srqe_exec_s;

  typedef struct packed {
    logic [7:0]  status;
    logic [31:0] sense_count;
    logic [31:0] bytes_read;
    logic [31:0] bytes_written;
    srqe_fault_e fault;
  } srqe_result_s;

  typedef struct packed {
    logic [7:0]  queue_id;
    logic [63:0] command_tag;
    logic [7:0]  response;
    logic [7:0]  status;
    logic [31:0] sense_len;
    logic [31:0] residual;
    logic [31:0] header_length;
    logic [31:0] datain_offset;
  } srqe_comp_s;
endpackage

// *** hdl/srqe_engine.sv ***
// Notes on behaviour
// - completion carries the queue id the request came from; queues unordered
// - address c1 01 and six zeros selects the report-luns well-known unit
// - target address: byte0 one, byte1 target, bytes2-3 lun, four zero bytes
// - attributes map to simple, or to head for implicit head-of-queue commands
// - attribute codes: simple 0, ordered 1, head 2, aca 3
// - reference number is one byte, normally zero
// - cdb field length follows the current cdb size setting
// - protection lengths exist only when protection feature negotiated
// - sense length equals bytes really written to sense buffer
// - residual is demanded length minus bytes read plus written
// - partial data-out means data-in untouched, residual above data-in size
// - status byte holds the scsi status from the target
// - ok response whenever a scsi status was produced
// - overrun when demanded length exceeds data-in plus data-out buffers
// - abort cancels with aborted response, reset cancels with reset response
// - bad target response without processing when target absent
// - transport failure code six on severed link
// - target, nexus or busy failure by retry prospects
// - code nine for other errors; unnegotiated bidirectional fails at once
// - before device reset every outstanding command completes with failure
// - reset restores sense size 96 and cdb size 32; driver may rewrite
// - feature bit zero allows bidirectional requests
`timescale 1ns/100ps
`include "srqe_cfg.svh"
module srqe_engine #(
  parameter logic [8:0] NUM_TARGETS = 9'h100
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [31:0]          features,
  input  wire logic                 cfg_wr_sense,
  input  wire logic                 cfg_wr_cdb,
  input  wire logic [31:0]          cfg_wdata,
  output logic [31:0]               sense_size,
  output logic [31:0]               cdb_size,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire srqe_pkg::srqe_req_s  req,
  output logic                      exec_valid,
  input  wire logic                 exec_ready,
  output srqe_pkg::srqe_exec_s      exec,
  input  wire logic                 res_valid,
  input  wire srqe_pkg::srqe_result_s res,
  input  wire logic                 abort_req,
  input  wire logic [63:0]          abort_tag,
  input  wire logic                 lun_reset_req,
  input  wire logic                 dev_reset_req,
  output logic                      dev_reset_done,
  output logic                      busy,
  output logic                      comp_valid,
  input  wire logic                 comp_ready,
  output srqe_pkg::srqe_comp_s      comp
);

  typedef enum logic [2:0] {SRQE_IDLE, SRQE_CHECK, SRQE_DISPATCH, SRQE_WAIT, SRQE_DONE} srqe_state_e;

  srqe_state_e          state_r, state_nxt;
  srqe_pkg::srqe_req_s  req_r, req_nxt;
  srqe_pkg::srqe_exec_s exec_r, exec_nxt;
  srqe_pkg::srqe_comp_s comp_r, comp_nxt;
  logic [31:0]          sense_size_r, sense_size_nxt;
  logic [31:0]          cdb_size_r, cdb_size_nxt;
  logic                 rst_done_r, rst_done_nxt;

  logic                 pi_on;
  logic                 inout_on;
  logic                 is_rlun;
  logic                 is_tgt_form;
  logic                 tgt_ok;
  logic [32:0]          buf_total;
  logic [32:0]          moved;
  logic [31:0]          rd_eff;
  logic [31:0]          sense_eff;
  logic [31:0]          hdr_len;

  // configuration group: driver may rewrite, device reset restores defaults
  always_comb begin
    sense_size_nxt = sense_size_r;
    cdb_size_nxt   = cdb_size_r;
    if (dev_reset_req && state_r == SRQE_IDLE) begin
      sense_size_nxt = `SRQE_SENSE_SIZE_RST;
      cdb_size_nxt   = `SRQE_CDB_SIZE_RST;
    end else begin
      if (cfg_wr_sense)
        sense_size_nxt = cfg_wdata;
      if (cfg_wr_cdb)
        cdb_size_nxt = cfg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_size_r <= `SRQE_SENSE_SIZE_RST;
      cdb_size_r   <= `SRQE_CDB_SIZE_RST;
    end else begin
      sense_size_r <= sense_size_nxt;
      cdb_size_r   <= cdb_size_nxt;
    end
  end

  // request decode helpers
  always_comb begin
    pi_on       = features[`SRQE_FEAT_INOUT_BIT + 3];
    inout_on    = features[`SRQE_FEAT_INOUT_BIT];
    is_rlun     = req_r.lun[7:0] == `SRQE_RLUN_BYTE0 && req_r.lun[15:8] == `SRQE_RLUN_BYTE1
                  && req_r.lun[63:16] == 48'h0000_0000_0000;
    is_tgt_form = req_r.lun[7:0] == `SRQE_ADDR_FORM_TARGET && req_r.lun[63:32] == 32'h0000_0000;
    tgt_ok      = is_rlun || (is_tgt_form && {1'b0, req_r.lun[15:8]} < NUM_TARGETS);
    buf_total   = {1'b0, req_r.datain_length} + {1'b0, req_r.dataout_length};
    hdr_len     = `SRQE_HDR_FIXED_BYTES + cdb_size_r + (pi_on ? `SRQE_HDR_PI_BYTES : 32'h0000_0000);
    // data-in counts only once data-out went through whole, so residual tells which half stalled
    rd_eff      = (res.bytes_written < req_r.dataout_length) ? 32'h0000_0000 : res.bytes_read;
    moved       = {1'b0, rd_eff} + {1'b0, res.bytes_written};
    sense_eff   = (res.sense_count > sense_size_r) ? sense_size_r : res.sense_count;
  end

  // main group
  always_comb begin
    state_nxt    = state_r;
    req_nxt      = req_r;
    exec_nxt     = exec_r;
    comp_nxt     = comp_r;
    rst_done_nxt = 1'b0;
    case (state_r)
      SRQE_IDLE: begin
        if (dev_reset_req) begin
          rst_done_nxt = 1'b1;
        end else if (req_valid) begin
          req_nxt   = req;
          state_nxt = SRQE_CHECK;
        end
      end
      SRQE_CHECK: begin
        comp_nxt               = '0;
        comp_nxt.queue_id      = req_r.queue_id;
        comp_nxt.command_tag   = req_r.command_tag;
        comp_nxt.header_length = hdr_len;
        comp_nxt.datain_offset = sense_size_r + (pi_on ? req_r.protect_in_length : 32'h0000_0000);
        comp_nxt.residual      = req_r.demand_length;
        exec_nxt.report_luns   = is_rlun;
        exec_nxt.target        = req_r.lun[15:8];
        // byte 2 carries the address method in its top two bits, byte 3 the low lun bits
        exec_nxt.unit          = {req_r.lun[21:16], req_r.lun[31:24]};
        exec_nxt.command_tag   = req_r.command_tag;
        exec_nxt.task_attr     = req_r.implicit_head ? `SRQE_ATTR_HEAD : `SRQE_ATTR_SIMPLE;
        exec_nxt.cdb_bytes     = cdb_size_r;
        exec_nxt.dataout_offset = pi_on ? req_r.protect_out_length : 32'h0000_0000;
        exec_nxt.dataout_length = req_r.dataout_length;
        exec_nxt.datain_length  = req_r.datain_length;
        state_nxt              = SRQE_DONE;
        if (dev_reset_req)
          comp_nxt.response = `SRQE_RESP_FAILURE;
        else if (req_r.dataout_length != 32'h0000_0000 && req_r.datain_length != 32'h0000_0000 && !inout_on)
          comp_nxt.response = `SRQE_RESP_FAILURE;
        else if (!tgt_ok)
          comp_nxt.response = `SRQE_RESP_BAD_TARGET;
        else if ({1'b0, req_r.demand_length} > buf_total)
          comp_nxt.response = `SRQE_RESP_OVERRUN;
        else
          state_nxt = SRQE_DISPATCH;
      end
      SRQE_DISPATCH, SRQE_WAIT: begin
        if (state_r == SRQE_DISPATCH && exec_ready)
          state_nxt = SRQE_WAIT;
        if (dev_reset_req) begin
          comp_nxt.response = `SRQE_RESP_FAILURE;
          state_nxt         = SRQE_DONE;
        end else if (lun_reset_req) begin
          comp_nxt.response = `SRQE_RESP_RESET;
          state_nxt         = SRQE_DONE;
        end else if (abort_req && abort_tag == req_r.command_tag) begin
          comp_nxt.response = `SRQE_RESP_ABORT;
          state_nxt         = SRQE_DONE;
        end else if (state_r == SRQE_WAIT && res_valid) begin
          comp_nxt.status    = res.status;
          comp_nxt.sense_len = sense_eff;
          comp_nxt.residual  = req_r.demand_length - moved[31:0];
          state_nxt          = SRQE_DONE;
          case (res.fault)
            srqe_pkg::SRQE_FAULT_NONE:      comp_nxt.response = `SRQE_RESP_OK;
            srqe_pkg::SRQE_FAULT_TRANSPORT: comp_nxt.response = `SRQE_RESP_TRANSPORT;
            srqe_pkg::SRQE_FAULT_TARGET:    comp_nxt.response = `SRQE_RESP_TGT_FAILURE;
            srqe_pkg::SRQE_FAULT_NEXUS:     comp_nxt.response = `SRQE_RESP_NEXUS;
            srqe_pkg::SRQE_FAULT_BUSY:      comp_nxt.response = `SRQE_RESP_BUSY;
            default:                        comp_nxt.response = `SRQE_RESP_FAILURE;
          endcase
        end
      end
      SRQE_DONE: begin
        // reset waits for this completion to drain first
        if (comp_ready)
          state_nxt = SRQE_IDLE;
      end
      default: state_nxt = SRQE_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= SRQE_IDLE;
      req_r      <= '0;
      exec_r     <= '0;
      comp_r     <= '0;
      rst_done_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      req_r      <= req_nxt;
      exec_r     <= exec_nxt;
      comp_r     <= comp_nxt;
      rst_done_r <= rst_done_nxt;
    end
  end

  assign req_ready      = state_r == SRQE_IDLE && !dev_reset_req;
  assign exec_valid     = state_r == SRQE_DISPATCH;
  assign exec           = exec_r;
  assign comp_valid     = state_r == SRQE_DONE;
  assign comp           = comp_r;
  assign sense_size     = sense_size_r;
  assign cdb_size       = cdb_size_r;
  assign dev_reset_done = rst_done_r;
  assign busy           = state_r != SRQE_IDLE;

  // checks
  property p_queue_kept;
    @(posedge clk) disable iff (!rst_n)
      (req_valid && req_ready) |-> ##[2:1000] (comp_valid && comp.queue_id == $past(req.queue_id, 1)) or !comp_valid;
  endproperty
  a_queue_id_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == SRQE_CHECK) |=> (comp_r.queue_id == $past(req_r.queue_id))) else $error("queue id lost");
  a_sense_reset_val: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dev_reset_done) |-> (sense_size == 32'h0000_0060 && cdb_size == 32'h0000_0020)) else $error("config defaults");
  a_bidir_fail_now: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == SRQE_CHECK && !dev_reset_req && req_r.dataout_length != 0 && req_r.datain_length != 0 && !features[0])
    |=> comp_valid && comp.response == 8'h09) else $error("bidir not failed");
  a_bad_target_resp: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == SRQE_CHECK && !dev_reset_req && (req_r.dataout_length == 0 || req_r.datain_length == 0) && !tgt_ok)
    |=> comp.response == 8'h03 && !exec_valid) else $error("bad target");
  a_sense_len_cap: assert property (@(posedge clk) disable iff (!rst_n)
    comp_valid |-> comp.sense_len <= sense_size) else $error("sense length over size");
  a_ok_has_status: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == SRQE_WAIT && res_valid && !dev_reset_req && !lun_reset_req && !(abort_req && abort_tag == req_r.command_tag)
     && res.fault == srqe_pkg::SRQE_FAULT_NONE) |=> comp.response == 8'h00 && comp.status == $past(res.status))
    else $error("ok response or status wrong");
  a_abort_resp: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == SRQE_WAIT && !dev_reset_req && !lun_reset_req && abort_req && abort_tag == req_r.command_tag)
    |=> comp_valid && comp.response == 8'h02) else $error("abort response");
  a_reset_drains: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && state_r != SRQE_DONE && dev_reset_req) |=> comp_valid && comp.response == 8'h09) else $error("reset drain");
  a_attr_mapped: assert property (@(posedge clk) disable iff (!rst_n)
    exec_valid |-> (exec.task_attr == 8'h00 || exec.task_attr == 8'h02)) else $error("attribute not mapped");
  a_cdb_follows_cfg: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == SRQE_CHECK) |=> ##[0:1] (exec.cdb_bytes == $past(cdb_size, 1) || !exec_valid)) else $error("cdb size");

  c_ok_path: cover property (@(posedge clk) disable iff (!rst_n) comp_valid && comp.response == 8'h00);
  c_overrun: cover property (@(posedge clk) disable iff (!rst_n) comp_valid && comp.response == 8'h01);
  c_abort: cover property (@(posedge clk) disable iff (!rst_n) comp_valid && comp.response == 8'h02);
  c_reset_done: cover property (@(posedge clk) disable iff (!rst_n) dev_reset_done);

endmodule // srqe_engine

// *** bench/srqe_backend_model.sv ***
`timescale 1ns/100ps
// target backend: takes a dispatch after lat edges, answers lat edges later
module srqe_backend_model (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            lat,
  input  wire srqe_pkg::srqe_result_s res_cfg,
  input  wire logic                  exec_valid,
  output logic                       exec_ready,
  output srqe_pkg::srqe_result_s     res,
  output logic                       res_valid
);
  initial begin
    exec_ready = 1'b0;
    res_valid  = 1'b0;
    res        = '0;
    forever begin
      @(posedge clk);
      if (exec_valid && rst_n) begin
        repeat (lat) @(posedge clk);
        exec_ready <= 1'b1;
        @(posedge clk);
        exec_ready <= 1'b0;
        repeat (lat) @(posedge clk);
        res       <= res_cfg;
        res_valid <= 1'b1;
        @(posedge clk);
        res_valid <= 1'b0;
        // released result lines show garbage, not the last answer
        res       <= srqe_pkg::srqe_result_s'(~res_cfg);
      end
    end
  end
endmodule // srqe_backend_model

// *** bench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  logic clk, rst_n, cfg_wr_sense, cfg_wr_cdb, req_valid, req_ready, exec_valid, exec_ready;
  logic res_valid, abort_req, lun_reset_req, dev_reset_req, dev_reset_done, busy, comp_valid;
  logic [31:0] features, cfg_wdata, sense_size, cdb_size;
  logic [63:0] abort_tag;
  logic [7:0] lat;
  srqe_pkg::srqe_req_s rq;
  srqe_pkg::srqe_exec_s exec, ex;
  srqe_pkg::srqe_result_s res, bres;
  srqe_pkg::srqe_comp_s comp, c;
  int n_errors, total_checks, cyc;
  srqe_pkg::srqe_fault_e flt [5] = '{srqe_pkg::SRQE_FAULT_TRANSPORT, srqe_pkg::SRQE_FAULT_TARGET,
    srqe_pkg::SRQE_FAULT_NEXUS, srqe_pkg::SRQE_FAULT_BUSY, srqe_pkg::SRQE_FAULT_OTHER};
  logic [7:0] fcode [5] = '{8'h06, 8'h07, 8'h08, 8'h05, 8'h09};

  srqe_engine #(.NUM_TARGETS(9'h004)) u_dut (.clk(clk), .rst_n(rst_n), .features(features),
    .cfg_wr_sense(cfg_wr_sense), .cfg_wr_cdb(cfg_wr_cdb), .cfg_wdata(cfg_wdata), .sense_size(sense_size),
    .cdb_size(cdb_size), .req_valid(req_valid), .req_ready(req_ready), .req(rq), .exec_valid(exec_valid),
    .exec_ready(exec_ready), .exec(exec), .res_valid(res_valid), .res(res), .abort_req(abort_req),
    .abort_tag(abort_tag), .lun_reset_req(lun_reset_req), .dev_reset_req(dev_reset_req),
    .dev_reset_done(dev_reset_done), .busy(busy), .comp_valid(comp_valid), .comp_ready(1'b1), .comp(comp));
  srqe_backend_model u_be (.clk(clk), .rst_n(rst_n), .lat(lat), .res_cfg(bres), .exec_valid(exec_valid),
    .exec_ready(exec_ready), .res(res), .res_valid(res_valid));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (exec_valid && exec_ready) ex <= exec;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one command at a time; the driver orders its own queues
  task automatic put();
    @(negedge clk) req_valid = 1'b1;
    for (int i = 0; i < 200; i++) begin
      if (req_ready === 1'b1) break;
      @(negedge clk);
    end
    @(posedge clk);
    @(negedge clk) req_valid = 1'b0;
  endtask
  task automatic get();
    for (int i = 0; i < 300; i++) begin
      if (comp_valid === 1'b1) begin
        c = comp;
        break;
      end
      @(negedge clk);
    end
    @(negedge clk);
  endtask
  task automatic pulse(input int k);
    @(negedge clk) {abort_req, lun_reset_req} = (k == 0) ? 2'b10 : 2'b01;
    @(negedge clk) {abort_req, lun_reset_req} = 2'b00;
  endtask
  function automatic logic [63:0] tl(input logic [7:0] t, input logic [13:0] u);
    return {32'h0, u[7:0], 2'b01, u[13:8], t, 8'h01};
  endfunction

  initial begin
    {rst_n, cfg_wr_sense, cfg_wr_cdb, req_valid, abort_req, lun_reset_req, dev_reset_req} = '0;
    {features, cfg_wdata, abort_tag} = '0;
    lat = 8'h01;
    rq = '0;
    bres = '0;
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    chk("sense_size", sense_size, 32'h60);
    chk("cdb_size", cdb_size, 32'h20);
    rq.queue_id = 8'h05; rq.lun = tl(8'h02, 14'h123); rq.command_tag = 64'h1111; rq.task_attr = 8'h01;
    rq.demand_length = 32'd100; rq.datain_length = 32'd200;
    bres.status = 8'h02; bres.sense_count = 32'd18; bres.bytes_read = 32'd60;
    put(); get();
    chk("queue", c.queue_id, 8'h05);
    chk("tag", c.command_tag, 64'h1111);
    chk("resp ok", c.response, 8'h00);
    chk("status", c.status, 8'h02);
    chk("residual", c.residual, 32'd40);
    chk("sense_len", c.sense_len, 32'd18);
    chk("hdr", c.header_length, 32'd51);
    chk("target", ex.target, 8'h02);
    chk("unit", ex.unit, 14'h123);
    chk("attr", ex.task_attr, 8'h00);
    chk("cdb_bytes", ex.cdb_bytes, 32'h20);
    rq.implicit_head = 1'b1; rq.task_attr = 8'h03; rq.lun = 64'h0000_0000_0000_01c1;
    bres.sense_count = 32'd200;
    put(); get();
    chk("attr head", ex.task_attr, 8'h02);
    chk("rluns", ex.report_luns, 1'b1);
    chk("sense clip", c.sense_len, 32'd96);
    rq.lun = tl(8'h07, 14'h0);
    put(); get();
    chk("bad tgt", c.response, 8'h03);
    chk("bad tgt res", c.residual, 32'd100);
    rq.lun = tl(8'h01, 14'h5); rq.demand_length = 32'd500; rq.dataout_length = 32'd100; rq.datain_length = 32'd0;
    put(); get();
    chk("overrun", c.response, 8'h01);
    rq.demand_length = 32'd100; rq.dataout_length = 32'd50; rq.datain_length = 32'd50;
    put(); get();
    chk("bidir off", c.response, 8'h09);
    features = 32'h1;
    bres.bytes_read = 32'd50; bres.bytes_written = 32'd50;
    put(); get();
    chk("bidir on", c.response, 8'h00);
    chk("bidir res", c.residual, 32'd0);
    rq.demand_length = 32'd200; rq.dataout_length = 32'd100; rq.datain_length = 32'd100;
    bres.bytes_read = 32'd30; bres.bytes_written = 32'd40;
    put(); get();
    chk("partial", c.residual, 32'd160);
    for (int i = 0; i < 5; i++) begin
      bres.fault = flt[i];
      put(); get();
      chk("fault", c.response, fcode[i]);
    end
    bres.fault = srqe_pkg::SRQE_FAULT_NONE;
    @(negedge clk) {cfg_wr_cdb, cfg_wdata} = {1'b1, 32'd16};
    @(negedge clk) cfg_wr_cdb = 1'b0;
    features = 32'h9;
    rq.protect_in_length = 32'd8; rq.protect_out_length = 32'd4;
    put(); get();
    chk("hdr pi", c.header_length, 32'd43);
    chk("din off", c.datain_offset, 32'd104);
    chk("dout off", ex.dataout_offset, 32'd4);
    chk("cdb cfg", ex.cdb_bytes, 32'd16);
    lat = 8'd20; rq.command_tag = 64'h77;
    for (int k = 0; k < 3; k++) begin
      put();
      repeat (30) @(negedge clk);
      chk("busy", busy, 1'b1);
      abort_tag = 64'h76;
      pulse(0);
      abort_tag = 64'h77;
      if (k < 2) pulse(k);
      else dev_reset_req = 1'b1;
      get();
      chk("cancel", c.response, (k == 0) ? 8'h02 : (k == 1) ? 8'h04 : 8'h09);
      repeat (40) @(negedge clk);
    end
    chk("rst done", dev_reset_done, 1'b1);
    chk("cdb back", cdb_size, 32'h20);
    dev_reset_req = 1'b0;
    end_sim();
  end
endmodule // testbench
